/* octal_driver_serial_control_port_tb.sv */
// Self-checking bench of the serial control port
`timescale 1ns/1ps
module octal_driver_serial_control_port_tb;
  reg clk_in = 1'b0;
  reg srst_in = 1'b1;
  reg [7:0] drain_r = 8'h0;
  reg [15:0] w;
  reg [31:0] rnd;
  wire sclk, sdi, csn, sdo, oe;
  wire [7:0] off;
  wire [15:0] rx;
  integer n_mismatch = 0, tests_run = 0, k, nb;
  initial forever #25 clk_in = ~clk_in;
  odscp_top DUT (.clk_in(clk_in), .srst_in(srst_in), .sclk_in(sclk), .sdi_in(sdi),
    .chip_select_n_in(csn), .drain_status_in(drain_r), .sdo_out(sdo),
    .sdo_oe_out(oe), .out_off_out(off));
  odscp_host host (.clk_in(clk_in), .sdo_in(oe ? sdo : ~sdo), .sclk_out(sclk),
    .sdi_out(sdi), .chip_select_n_out(csn), .rx_out(rx));
  task chk(input [15:0] seen, input [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Status word first, then the oldest command bits pushed through
  function [15:0] exp_rx(input [7:0] d, input [15:0] cw, input integer n);
    exp_rx = ({8'h0, d} << (n - 8)) | (cw >> 8);
  endfunction
  task tally_and_finish;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #500000 n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial begin
    k = $urandom(56);
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(off, 16'hff);
    chk(oe, 1'b0);
    for (k = 0; k < 8; k = k + 1) begin
      nb = (k < 5) ? 8 : 8 + k;
      rnd = $urandom;
      w = (k == 0) ? 16'h0 : (k == 1) ? 16'hffff : rnd[15:0];
      w = w & ((16'h1 << nb) - 16'h1);
      @(posedge clk_in) drain_r <= rnd[23:16];
      host.frame(w, nb, 1'b1);
      chk(off, w[7:0]);
      chk(rx & ((16'h1 << nb) - 16'h1), exp_rx(drain_r, w, nb));
      chk(oe, 1'b0);
    end
    host.frame(16'h5a, 8, 1'b0);
    chk(off, w[7:0]);
    tally_and_finish;
  end
endmodule
bind odscp_top odscp_props #(.NUM_OUT(NUM_OUT)) u_props (.clk_in(clk_in), .srst_in(srst_in),
  .sclk_in(sclk_in), .chip_select_n_in(chip_select_n_in), .drain_status_in(drain_status_in),
  .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .out_off_out(out_off_out));

/* odscp_host.sv */
// Host model, master of the serial control port
`timescale 1ns/1ps
module odscp_host (
  input wire clk_in,
  input wire sdo_in,
  output reg sclk_out = 1'b0,
  output reg sdi_out = 1'b0,
  output reg chip_select_n_out = 1'b1,
  output reg [15:0] rx_out = 16'h0
);
  task automatic frame(input [15:0] w, input integer nb, input sel);
    integer i;
    chip_select_n_out <= !sel;
    repeat (8) @(posedge clk_in);
    for (i = nb - 1; i >= 0; i = i - 1) begin
      sdi_out <= w[i];
      @(posedge clk_in) sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
      #1 rx_out = {rx_out[14:0], sdo_in};
      repeat (3) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
    chip_select_n_out <= 1'b1;
    sdi_out <= !sdi_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

/* odscp_map.vh */
// Constants of the octal driver serial control port
// Functional notes
// - Input bit is captured on serial clock falling edge while selected.
// - Serial output moves to next register bit on each serial clock rising edge.
// - Deselected: clock and data ignored, serial output high impedance.
// - A one bit turns its output off at chip select rise.
// - A zero bit turns its output on at chip select rise.
// - One bit enters per serial clock; register full after eight bits.
// - Chip select fall loads drain status of all outputs into the register.
// - Status bit high for off output, low for on output.
// - Input and output words move most significant bit first, FIFO order.
// - Serial output does not depend on the reset input.
`ifndef ODSCP_MAP_VH
`define ODSCP_MAP_VH
`define ODSCP_NUM_OUT 8
`define ODSCP_CMD_RST 8'hff
`define ODSCP_MSB 7
`endif

/* odscp_props.sv */
// Pin assertions of the serial control port
`timescale 1ns/1ps
module odscp_props #(parameter NUM_OUT = 8) (
  input wire clk_in,
  input wire srst_in,
  input wire sclk_in,
  input wire chip_select_n_in,
  input wire [NUM_OUT-1:0] drain_status_in,
  input wire sdo_out,
  input wire sdo_oe_out,
  input wire [NUM_OUT-1:0] out_off_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence desel_s; chip_select_n_in [*6]; endsequence
  sequence sel_s; !chip_select_n_in [*5]; endsequence
  oe_on_a: assert property ($fell(chip_select_n_in) |-> ##[3:4] sdo_oe_out) else $error("oe");
  oe_off_a: assert property ($rose(chip_select_n_in) |-> ##[3:4] !sdo_oe_out) else $error("oe");
  desel_idle_a: assert property (desel_s |-> !sdo_oe_out && $stable(out_off_out))
    else $error("idle");
  sel_hold_a: assert property (sel_s |-> $stable(out_off_out)) else $error("hold");
  cmd_apply_a: assert property ($changed(out_off_out) |-> $past(chip_select_n_in, 2))
    else $error("apply");
  status_first_a: assert property ($rose(sdo_oe_out) |-> sdo_out == drain_status_in[NUM_OUT-1])
    else $error("status");
  sdo_rise_a: assert property (sdo_oe_out && $past(sdo_oe_out) && $changed(sdo_out)
    |-> $past(sclk_in, 2)) else $error("shift");
  sdo_hold_a: assert property ($fell(sclk_in) && sdo_oe_out |-> ##2 $stable(sdo_out) [*3])
    else $error("hold");
endmodule

/* odscp_sync.v */
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module odscp_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire clk_in,
  input wire srst_in,
  input wire d_in,
  output reg q_out
);
  reg meta_r;
  always @(posedge clk_in) begin
    if (srst_in) begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

/* odscp_top.v */
// Serial control port of the octal low-side driver
`timescale 1ns/1ps
`include "odscp_map.vh"
module odscp_top #(
  parameter NUM_OUT = `ODSCP_NUM_OUT
) (
  input wire clk_in,
  input wire srst_in,
  input wire sclk_in,
  input wire sdi_in,
  input wire chip_select_n_in,
  input wire [NUM_OUT-1:0] drain_status_in,
  output reg sdo_out,
  output reg sdo_oe_out,
  output reg [NUM_OUT-1:0] out_off_out
);
  // ==========================================================
  // Input synchronisers
  // Every pin is asynchronous to clk_in and passes two flip-flops first
  wire sclk_s;
  wire sdi_s;
  wire cs_n_s;
  wire [NUM_OUT-1:0] drain_s;

  odscp_sync #(
    .RST_VAL(1'b0)
  ) u_sync_sclk (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in(sclk_in),
    .q_out(sclk_s)
  );

  odscp_sync #(
    .RST_VAL(1'b0)
  ) u_sync_sdi (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in(sdi_in),
    .q_out(sdi_s)
  );

  // Select rests high, so a released select never looks like a fall
  odscp_sync #(
    .RST_VAL(1'b1)
  ) u_sync_cs (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in(chip_select_n_in),
    .q_out(cs_n_s)
  );

  // Drain status is a slow level, so each bit is sampled on its own
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_drain
      odscp_sync #(
        .RST_VAL(1'b1)
      ) u_sync_drain (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .d_in(drain_status_in[gi]),
        .q_out(drain_s[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Edge detection
  // Rest values equal the idle pin levels, so reset makes no false edge
  reg sclk_d_r;
  reg cs_n_d_r;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire cs_rise;

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign cs_fall = ~cs_n_s & cs_n_d_r;
  assign cs_rise = cs_n_s & ~cs_n_d_r;

  always @(posedge clk_in) begin
    if (srst_in) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      cs_n_d_r <= 1'b1;
    end else begin
      cs_n_d_r <= cs_n_s;
    end
  end

  // ==========================================================
  // Frame state
  // A frame opens at the select fall and closes at the select rise
  localparam FRM_IDLE = 1'b0;
  localparam FRM_OPEN = 1'b1;
  reg frm_r;
  reg frm_nxt;
  wire selected;

  always @* begin
    frm_nxt = frm_r;
    case (frm_r)
      FRM_IDLE: begin
        if (cs_fall) begin
          frm_nxt = FRM_OPEN;
        end
      end
      FRM_OPEN: begin
        if (cs_rise) begin
          frm_nxt = FRM_IDLE;
        end
      end
      default: begin
        frm_nxt = FRM_IDLE;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      frm_r <= FRM_IDLE;
    end else begin
      frm_r <= frm_nxt;
    end
  end

  // Serial clock and data count only inside an open frame
  assign selected = (frm_r == FRM_OPEN) & ~cs_n_s;

  // ==========================================================
  // Shift register
  // Select fall loads the drain status; every serial clock fall then
  // moves the word toward the top bit, so the oldest bit leaves first
  reg [NUM_OUT-1:0] shift_r;
  reg [NUM_OUT-1:0] shift_nxt;

  always @* begin
    shift_nxt = shift_r;
    if (cs_fall) begin
      // Drain high means output off and healthy
      shift_nxt = drain_s;
    end else if (selected && sclk_fall) begin
      shift_nxt = {shift_r[NUM_OUT-2:0], sdi_s};
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      shift_r <= {NUM_OUT{1'b1}};
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // ==========================================================
  // Serial data output
  // The top bit goes out at the select fall and at every serial clock
  // rise; the host takes it at the following fall
  reg sdo_nxt;

  always @* begin
    sdo_nxt = sdo_out;
    if (cs_fall) begin
      sdo_nxt = drain_s[NUM_OUT-1];
    end else if (selected && sclk_rise) begin
      sdo_nxt = shift_r[NUM_OUT-1];
    end
  end

  // Only srst_in clears this path; no driver reset reaches it
  always @(posedge clk_in) begin
    if (srst_in) begin
      sdo_out <= 1'b0;
    end else begin
      sdo_out <= sdo_nxt;
    end
  end

  // ==========================================================
  // Serial output enable
  // The pin is driven only while selected and floats otherwise
  reg sdo_oe_nxt;

  always @* begin
    sdo_oe_nxt = ~cs_n_s;
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      sdo_oe_out <= 1'b0;
    end else begin
      sdo_oe_out <= sdo_oe_nxt;
    end
  end

  // ==========================================================
  // Output command latch
  // Outputs take the word only at the select rise, so with extra bits
  // the last ones shifted in are applied
  reg [NUM_OUT-1:0] out_off_nxt;

  always @* begin
    out_off_nxt = out_off_out;
    if (cs_rise) begin
      // One turns an output off, zero turns it on
      out_off_nxt = shift_r;
    end
  end

  // Every output starts off
  always @(posedge clk_in) begin
    if (srst_in) begin
      out_off_out <= `ODSCP_CMD_RST;
    end else begin
      out_off_out <= out_off_nxt;
    end
  end
endmodule
